// >>> swb_pkg.sv
package swb_pkg;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses, one aligned word each)
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_HOLD   = 8'h00;
    localparam logic [7:0] ADDR_SIZE_L = 8'h04;
    localparam logic [7:0] ADDR_SIZE_H = 8'h08;
    localparam logic [7:0] ADDR_CLKSEL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CTRL   = 8'h14;
    localparam logic [7:0] ADDR_RAM    = 8'h40;
    localparam logic [7:0] ADDR_RAM_M  = 8'hC0;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int          POS_AUTO      = 3;
    localparam int          POS_START     = 2;
    localparam int          POS_SELECT    = 3;
    localparam int          POS_ST_FLAG   = 0;
    localparam int          POS_ST_IRQ    = 1;
    localparam int          POS_ST_BUSY   = 2;
    localparam int          POS_ST_IEN    = 3;
    localparam int          POS_CT_HALT   = 0;
    localparam int          POS_CT_IEN    = 1;
    localparam int          POS_CT_PEND   = 2;
    localparam int          POS_CT_PORTD  = 3;
    localparam logic [3:0]  RST_HOLD      = 4'hF;
    localparam logic [3:0]  RST_NIBBLE    = 4'h0;
    localparam int          RAM_WORDS     = 64;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    // -------------------------------------------------------------------
    // Serial clock rates: half periods in aclk cycles
    // -------------------------------------------------------------------
    localparam int CLK_HZ    = 125_000_000;
    localparam int RATE0_HZ  = 1024;
    localparam int RATE1_HZ  = 2048;
    localparam int RATE2_HZ  = 8192;
    localparam int RATE3_HZ  = 16384;
    localparam int HALF0     = CLK_HZ / (2 * RATE0_HZ);
    localparam int HALF1     = CLK_HZ / (2 * RATE1_HZ);
    localparam int HALF2     = CLK_HZ / (2 * RATE2_HZ);
    localparam int HALF3     = CLK_HZ / (2 * RATE3_HZ);
    localparam int DIV_W     = 16;

    typedef enum {
        ST_IDLE,
        ST_LOAD,
        ST_SHIFT
    } shift_state_t;

    typedef struct packed {
        logic [3:0] data;
        logic       valid;
    } nibble_t;

endpackage

// >>> swb_rate_gen.sv
`timescale 1ns/100ps
`default_nettype none
module swb_rate_gen (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] rate_sel,
    // Tick out
    output logic            tick
);
    logic [swb_pkg::DIV_W-1:0] count;
    logic [swb_pkg::DIV_W-1:0] half;

    always_comb begin
        case (rate_sel)
            2'h0:    half = swb_pkg::DIV_W'(swb_pkg::HALF0);
            2'h1:    half = swb_pkg::DIV_W'(swb_pkg::HALF1);
            2'h2:    half = swb_pkg::DIV_W'(swb_pkg::HALF2);
            default: half = swb_pkg::DIV_W'(swb_pkg::HALF3);
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            count <= '0;
        end else if (count >= half - 16'h0001) begin
            count <= '0;
        end else begin
            count <= count + 16'h0001;
        end
    end

    assign tick = run && (count >= half - 16'h0001);
endmodule
`default_nettype wire

// >>> swb_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module swb_shifter (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Control
    input  wire logic             tick,
    input  wire logic             abort,
    input  wire swb_pkg::nibble_t load,
    output logic                  load_ready,
    output logic                  busy,
    // Serial out
    output logic                  sclk,
    output logic                  sdata
);
    swb_pkg::shift_state_t state;
    logic [3:0] shreg;
    logic [1:0] bit_idx;

    // Ready to take a nibble at the last bit's falling edge or idle
    assign load_ready = (state == swb_pkg::ST_IDLE)
                      || (state == swb_pkg::ST_SHIFT && tick && sclk
                          && bit_idx == 2'h3);
    assign busy = (state != swb_pkg::ST_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn || abort) begin
            state   <= swb_pkg::ST_IDLE;
            shreg   <= swb_pkg::RST_NIBBLE;
            bit_idx <= 2'h0;
            sclk    <= 1'b0;
            if (!aresetn) begin
                sdata <= 1'b0;
            end
        end else begin
            case (state)
                swb_pkg::ST_IDLE: begin
                    if (load.valid) begin
                        shreg   <= load.data;
                        bit_idx <= 2'h0;
                        state   <= swb_pkg::ST_LOAD;
                    end
                end
                swb_pkg::ST_LOAD: begin
                    if (tick) begin
                        sclk  <= 1'b1;
                        sdata <= shreg[0];
                        state <= swb_pkg::ST_SHIFT;
                    end
                end
                default: begin
                    if (tick && sclk) begin
                        sclk <= 1'b0;
                        if (bit_idx == 2'h3) begin
                            if (load.valid) begin
                                shreg   <= load.data;
                                bit_idx <= 2'h0;
                                state   <= swb_pkg::ST_LOAD;
                            end else begin
                                state <= swb_pkg::ST_IDLE;
                            end
                        end else begin
                            bit_idx <= bit_idx + 2'h1;
                        end
                    end else if (tick) begin
                        sclk  <= 1'b1;
                        sdata <= shreg[bit_idx];
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> serial_write_buffer.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Auto sends holding nibble, then RAM 0..size.
// - Auto transfer is 8 to 260 bits.
// - Auto starts on halt with auto bit.
// - Interrupt enable forced off during auto.
// - Auto end: flag up, auto clear, wake.
// - Resume after halt, or pending interrupt first.
// - Flag holds until holding register written.
// - Nibble moved to shifter raises empty interrupt; code raises it in interactive mode only, never during auto.
// - Early reload sends next nibble without gap.
// - Holding write clears empty interrupt and flag.
// - Empties repeat until done, start then clears.
// - Clearing start stops transmission at once.
// - Data changes on rising serial clock edge.
// - Clock on port D line 0, data line 1.
module serial_write_buffer (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Core coupling
    input  wire logic        halt_exec,
    input  wire logic        irq_pending,
    output logic             standby,
    output logic             resume_irq,
    output logic             global_irq_enable,
    output logic             holding_empty_irq,
    output logic             jump_test_flag,
    // Port D pins
    output logic [1:0]       port_d_out,
    output logic [1:0]       port_d_oe
);
    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    logic [3:0]  tx_holding_nibble;
    logic        hold_full;
    logic [3:0]  size_low_reg;
    logic [1:0]  size_high_bits;
    logic        auto_mode_select;
    logic        interactive_start;
    logic        serial_buffer_select;
    logic [1:0]  rate_sel;
    logic        port_d_output;
    logic        irq_enable_sw;
    logic        pend_seen;
    logic [3:0]  ram [swb_pkg::RAM_WORDS];
    logic        auto_run;
    logic [5:0]  ram_ptr;
    logic        ram_left;
    logic [5:0]  size;

    // -------------------------------------------------------------------
    // Bus handshake
    // -------------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_fire;
    logic        hold_wr;
    logic        start_wr;
    logic        start_wval;
    logic        shifter_ready;
    logic        shifter_busy;
    logic        tick;
    logic        abort;
    logic        auto_done;
    logic        sclk;
    logic        sdata;
    swb_pkg::nibble_t load;

    assign size = {size_high_bits, size_low_reg};
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= swb_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == swb_pkg::ADDR_HOLD || aw_addr == swb_pkg::ADDR_SIZE_L
                || aw_addr == swb_pkg::ADDR_SIZE_H
                || aw_addr == swb_pkg::ADDR_CLKSEL
                || aw_addr == swb_pkg::ADDR_CTRL
                || (aw_addr >= swb_pkg::ADDR_RAM
                    && aw_addr < swb_pkg::ADDR_RAM_M)) begin
                s_axi_bresp <= swb_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= swb_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign hold_wr  = wr_fire && w_strb[0] && aw_addr == swb_pkg::ADDR_HOLD;
    assign start_wr = wr_fire && w_strb[0]
                    && aw_addr == swb_pkg::ADDR_SIZE_H;
    assign start_wval = w_data[swb_pkg::POS_START];

    // -------------------------------------------------------------------
    // Control and size registers
    // -------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            size_low_reg         <= swb_pkg::RST_NIBBLE;
            size_high_bits       <= 2'h0;
            rate_sel             <= 2'h0;
            serial_buffer_select <= 1'b0;
            port_d_output        <= 1'b0;
            irq_enable_sw        <= 1'b0;
        end else if (wr_fire && w_strb[0]) begin
            if (aw_addr == swb_pkg::ADDR_SIZE_L) begin
                size_low_reg <= w_data[3:0];
            end else if (aw_addr == swb_pkg::ADDR_SIZE_H) begin
                size_high_bits <= w_data[1:0];
            end else if (aw_addr == swb_pkg::ADDR_CLKSEL) begin
                rate_sel             <= w_data[1:0];
                serial_buffer_select <= w_data[swb_pkg::POS_SELECT];
            end else if (aw_addr == swb_pkg::ADDR_CTRL) begin
                irq_enable_sw <= w_data[swb_pkg::POS_CT_IEN];
                port_d_output <= w_data[swb_pkg::POS_CT_PORTD];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_fire && w_strb[0] && aw_addr >= swb_pkg::ADDR_RAM
            && aw_addr < swb_pkg::ADDR_RAM_M) begin
            ram[aw_addr[7:2] - 6'h10] <= w_data[3:0];
        end
    end

    // -------------------------------------------------------------------
    // Holding register and flags
    // -------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_holding_nibble <= swb_pkg::RST_HOLD;
            hold_full         <= 1'b0;
        end else if (hold_wr) begin
            tx_holding_nibble <= w_data[3:0];
            hold_full         <= 1'b1;
        end else if (load.valid && shifter_ready) begin
            hold_full <= 1'b0;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            jump_test_flag    <= 1'b0;
            holding_empty_irq <= 1'b0;
        end else if (auto_done) begin
            jump_test_flag <= 1'b1;
        end else if (interactive_start && !auto_run && shifter_ready
                     && (load.valid || shifter_busy)) begin
            jump_test_flag    <= 1'b1;
            holding_empty_irq <= 1'b1;
        end else if (hold_wr) begin
            jump_test_flag    <= 1'b0;
            holding_empty_irq <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Mode bits and automatic sequencing
    // -------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_mode_select  <= 1'b0;
            interactive_start <= 1'b0;
        end else if (start_wr) begin
            auto_mode_select  <= w_data[swb_pkg::POS_AUTO];
            interactive_start <= start_wval;
        end else begin
            if (auto_done) begin
                auto_mode_select <= 1'b0;
            end
            if (interactive_start && !hold_full && !shifter_busy
                && !load.valid) begin
                interactive_start <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_run <= 1'b0;
            ram_ptr  <= 6'h00;
            ram_left <= 1'b0;
        end else if (!auto_run) begin
            if (halt_exec && auto_mode_select) begin
                auto_run <= 1'b1;
                ram_ptr  <= 6'h00;
                ram_left <= 1'b1;
            end
        end else if (auto_done) begin
            auto_run <= 1'b0;
        end else if (load.valid && shifter_ready && !hold_full) begin
            if (ram_ptr == size) begin
                ram_left <= 1'b0;
            end else begin
                ram_ptr <= ram_ptr + 6'h01;
            end
        end
    end

    assign auto_done = auto_run && !ram_left && !hold_full && !shifter_busy
                     && !load.valid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_seen <= 1'b0;
        end else if (auto_run) begin
            pend_seen <= pend_seen || irq_pending;
        end else if (!halt_exec) begin
            pend_seen <= 1'b0;
        end
    end

    assign standby = auto_run;
    assign resume_irq = auto_done && (pend_seen || irq_pending);
    assign global_irq_enable = irq_enable_sw && !auto_mode_select;

    // -------------------------------------------------------------------
    // Shift path
    // -------------------------------------------------------------------
    always_comb begin
        load.valid = 1'b0;
        load.data  = tx_holding_nibble;
        if (auto_run) begin
            load.valid = hold_full || ram_left;
            load.data  = hold_full ? tx_holding_nibble : ram[ram_ptr];
        end else if (interactive_start) begin
            load.valid = hold_full;
        end
    end

    assign abort = !auto_run && !interactive_start;

    swb_rate_gen u_rate (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (shifter_busy),
        .rate_sel (rate_sel),
        .tick     (tick)
    );

    swb_shifter u_shift (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .tick       (tick),
        .abort      (abort),
        .load       (load),
        .load_ready (shifter_ready),
        .busy       (shifter_busy),
        .sclk       (sclk),
        .sdata      (sdata)
    );

    assign port_d_out = {sdata, sclk};
    assign port_d_oe  = {2{serial_buffer_select && port_d_output}};

    // -------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= swb_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= swb_pkg::RESP_OKAY;
            if (s_axi_araddr == swb_pkg::ADDR_HOLD) begin
                s_axi_rdata <= {28'h0, tx_holding_nibble};
            end else if (s_axi_araddr == swb_pkg::ADDR_SIZE_L) begin
                s_axi_rdata <= {28'h0, size_low_reg};
            end else if (s_axi_araddr == swb_pkg::ADDR_SIZE_H) begin
                s_axi_rdata <= {28'h0, auto_mode_select, interactive_start,
                                size_high_bits};
            end else if (s_axi_araddr == swb_pkg::ADDR_CLKSEL) begin
                s_axi_rdata <= {28'h0, serial_buffer_select, 1'b0, rate_sel};
            end else if (s_axi_araddr == swb_pkg::ADDR_STATUS) begin
                s_axi_rdata <= {28'h0, global_irq_enable, shifter_busy,
                                holding_empty_irq, jump_test_flag};
            end else if (s_axi_araddr == swb_pkg::ADDR_CTRL) begin
                s_axi_rdata <= {28'h0, port_d_output, pend_seen,
                                irq_enable_sw, auto_run};
            end else if (s_axi_araddr >= swb_pkg::ADDR_RAM
                         && s_axi_araddr < swb_pkg::ADDR_RAM_M) begin
                s_axi_rdata <= {28'h0, ram[s_axi_araddr[7:2] - 6'h10]};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= swb_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
endmodule
`default_nettype wire

// >>> swb_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
module swb_checker (
    // Clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // Bus and core
    input wire logic [7:0] s_axi_awaddr,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid,
    input wire logic       irq_pending,
    input wire logic       standby,
    input wire logic       resume_irq,
    input wire logic       global_irq_enable,
    input wire logic       holding_empty_irq,
    input wire logic       jump_test_flag,
    // Port D pins
    input wire logic [1:0] port_d_out,
    input wire logic [1:0] port_d_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic hold_wr;
    logic pend_in_standby;
    // ------------------------------------
    // Checks
    // ------------------------------------
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            hold_wr <= s_axi_awaddr == swb_pkg::ADDR_HOLD;
        end
    end
    always_ff @(posedge aclk) begin
        pend_in_standby <= standby && (pend_in_standby || irq_pending);
    end
    a_ien_off: assert property (standby |-> !global_irq_enable)
        else $error("irq enable on in standby");
    a_end_flag:
        assert property ($fell(standby) |-> ##[0:1] jump_test_flag)
        else $error("no flag at auto end");
    a_resume_cause:
        assert property (resume_irq |-> irq_pending || pend_in_standby)
        else $error("resume without pending irq");
    a_empty_flag:
        assert property ($rose(holding_empty_irq) |-> jump_test_flag)
        else $error("empty irq without flag");
    a_hold_clears:
        assert property ($rose(s_axi_bvalid) && hold_wr |->
            ##[0:2] !jump_test_flag && !holding_empty_irq)
        else $error("holding write did not clear");
    a_data_held:
        assert property ($fell(port_d_out[0]) |-> $stable(port_d_out[1]))
        else $error("data moved on falling clock");
    a_clk_pins:
        assert property ($rose(port_d_out[0]) |-> port_d_oe == 2'b11)
        else $error("serial clock while pins off");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    c_auto_end: cover property ($fell(standby));
    c_empty: cover property ($rose(holding_empty_irq));
    c_resume: cover property (resume_irq);
endmodule
bind serial_write_buffer swb_checker u_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_bvalid, .irq_pending, .standby, .resume_irq, .global_irq_enable,
    .holding_empty_irq, .jump_test_flag, .port_d_out, .port_d_oe
);
`default_nettype wire

// >>> swb_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module swb_rx_model (
    // Clock
    input  wire logic   aclk,
    // Serial pins
    input  wire logic   sclk,
    input  wire logic   sdata,
    // Received bits, newest on top
    output logic [7:0]  bit_count,
    output logic [31:0] rx_bits
);
    logic sclk_q;
    initial begin
        sclk_q = 1'b0;
        bit_count = 8'h00;
    end
    // Sample on falling clock, first bit ends lowest
    always @(posedge aclk) begin
        sclk_q <= sclk;
        if (sclk_q && !sclk) begin
            bit_count <= bit_count + 8'h01;
            rx_bits   <= {sdata, rx_bits[31:1]};
        end
    end
endmodule
`default_nettype wire

// >>> serial_write_buffer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module serial_write_buffer_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, halt_exec = 1'b0, seen;
    logic        irq_pending = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, mark, bit_count;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rx_bits;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, standby, resume_irq, global_irq_enable;
    logic        holding_empty_irq, jump_test_flag;
    logic [1:0]  s_axi_bresp, s_axi_rresp, port_d_out, port_d_oe;
    int          failures = 0, compares = 0, n;
    serial_write_buffer dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .halt_exec, .irq_pending, .standby,
        .resume_irq, .global_irq_enable, .holding_empty_irq,
        .jump_test_flag, .port_d_out, .port_d_oe
    );
    swb_rx_model rx (
        .aclk, .sclk(port_d_out[0]), .sdata(port_d_out[1]), .bit_count,
        .rx_bits
    );
    initial begin
        forever #4 aclk = ~aclk;
    end
    // ------------------------------------
    // Tasks
    // ------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [3:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {28'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp, input logic [1:0] resp);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(what, exp, s_axi_rdata);
        chk("read resp", {30'h0, resp}, {30'h0, s_axi_rresp});
    endtask
    task automatic results;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end
        else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (95000) @(posedge aclk);
        failures++;
        results();
    end
    // ------------------------------------
    // Tests
    // ------------------------------------
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk("holding", swb_pkg::ADDR_HOLD, 32'hF, swb_pkg::RESP_OKAY);
        rd_chk("unmapped", 8'h30, 32'h0, swb_pkg::RESP_SLVERR);
        wr_reg(swb_pkg::ADDR_CLKSEL, 4'hB);
        wr_reg(swb_pkg::ADDR_CTRL, 4'hA);
        wr_reg(swb_pkg::ADDR_HOLD, 4'h5);
        wr_reg(swb_pkg::ADDR_RAM, 4'hC);
        wr_reg(swb_pkg::ADDR_SIZE_L, 4'h0);
        wr_reg(swb_pkg::ADDR_SIZE_H, 4'h8);
        chk("ien auto", 32'h0, {31'h0, global_irq_enable});
        mark = bit_count;
        halt_exec <= 1'b1;
        irq_pending <= 1'b1;
        @(posedge aclk);
        halt_exec <= 1'b0;
        @(posedge aclk);
        chk("standby", 32'h1, {31'h0, standby});
        seen = 1'b0;
        for (n = 0; n < 3; n += int'(!standby)) begin
            @(posedge aclk);
            seen = seen | resume_irq;
        end
        irq_pending <= 1'b0;
        chk("auto bits", 32'h8, {24'h0, bit_count - mark});
        chk("auto data", 32'hC5, {24'h0, rx_bits[31:24]});
        chk("end flag", 32'h1, {31'h0, jump_test_flag});
        chk("ien back", 32'h1, {31'h0, global_irq_enable});
        chk("resume", 32'h1, {31'h0, seen});
        rd_chk("size high", swb_pkg::ADDR_SIZE_H, 32'h0, 2'b00);
        wr_reg(swb_pkg::ADDR_HOLD, 4'h9);
        chk("flag clear", 32'h0, {31'h0, jump_test_flag});
        mark = bit_count;
        wr_reg(swb_pkg::ADDR_SIZE_H, 4'h4);
        while (!holding_empty_irq) @(posedge aclk);
        chk("empty flag", 32'h1, {31'h0, jump_test_flag});
        wr_reg(swb_pkg::ADDR_HOLD, 4'h3);
        chk("empty clr", 32'h0, {30'h0, holding_empty_irq, jump_test_flag});
        while (bit_count - mark < 8'h02) @(posedge aclk);
        wr_reg(swb_pkg::ADDR_SIZE_H, 4'h0);
        mark = bit_count;
        repeat (10000) @(posedge aclk);
        chk("abort bits", 32'h0, {24'h0, bit_count - mark});
        chk("first bits", 32'h1, {30'h0, rx_bits[31:30]});
        wr_reg(swb_pkg::ADDR_HOLD, 4'h0);
        results();
    end
endmodule
`default_nettype wire
